// file: hw/sbkc_top.sv
// module: standby keep-alive control with APB register access
// ----------------------------------------
// ----------------------------------------
module sbkc_top
  import sbkc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // standby controls
  output logic OSC_KEEP,
  output logic CHECKS_ON,
  output logic [3:0] OUTPUTS_EN,
  output logic [7:0] SWITCH_EN,
  output logic [7:0] BURNOUT_EN,
  output logic OUTPUT_FOUR_EN,
  output logic OUTPUT_FOUR_LEVEL
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  sbkc_policy_if pol ();
  sbkc_apb_state_t state_reg;
  logic [15:0] retention_reg;
  logic [15:0] context_reg;
  logic [15:0] setup_reg;
  logic wr_fire;
  logic rd_fire;

  // no wait cycles: setup, access with pready, done
  assign wr_fire = PSEL & PENABLE & PWRITE & PREADY;
  assign rd_fire = PSEL & ~PENABLE & ~PWRITE;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == SBKC_RETENTION_ADDR) | (a == SBKC_CONTEXT_ADDR) |
             (a == SBKC_SETUP_ADDR) | (a == SBKC_STATUS_ADDR);
  endfunction

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= SBKC_IDLE;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      case (state_reg)
        SBKC_IDLE: begin
          PREADY <= 1'b0;
          PSLVERR <= 1'b0;
          if (PSEL & ~PENABLE) begin
            state_reg <= SBKC_ACCESS;
            PREADY <= 1'b1;
            PSLVERR <= ~mapped(PADDR);
          end
        end
        SBKC_ACCESS: begin
          state_reg <= SBKC_IDLE;
          PREADY <= 1'b0;
          PSLVERR <= 1'b0;
        end
        default: state_reg <= SBKC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      retention_reg <= SBKC_RETENTION_RESET;
      context_reg <= SBKC_CONTEXT_RESET;
      setup_reg <= SBKC_SETUP_RESET;
    end else if (wr_fire) begin
      if (PADDR == SBKC_RETENTION_ADDR) begin
        retention_reg <= PWDATA[15:0] & SBKC_RETENTION_WMASK;
      end
      if (PADDR == SBKC_CONTEXT_ADDR) begin
        context_reg <= PWDATA[15:0];
      end
      if (PADDR == SBKC_SETUP_ADDR) begin
        setup_reg <= PWDATA[15:0];
      end
    end
  end

  // read data is latched in setup so it is stable with pready
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= SBKC_UNMAPPED_DATA;
    end else if (rd_fire) begin
      case (PADDR)
        SBKC_RETENTION_ADDR: PRDATA <= {16'h0000, retention_reg};
        SBKC_CONTEXT_ADDR: PRDATA <= {16'h0000, context_reg};
        SBKC_SETUP_ADDR: PRDATA <= {16'h0000, setup_reg};
        SBKC_STATUS_ADDR: PRDATA <= {6'h00, BURNOUT_EN, SWITCH_EN, OUTPUTS_EN, 1'b0,
                                     OUTPUT_FOUR_LEVEL, OUTPUT_FOUR_EN, CHECKS_ON, 1'b0, OSC_KEEP};
        default: PRDATA <= SBKC_UNMAPPED_DATA;
      endcase
    end
  end

  assign pol.retention = retention_reg;
  assign pol.context_bits = context_reg;
  assign pol.setup = setup_reg;

  sbkc_gate u_gate (
    .pol(pol)
  );

  // ----------------------------------------
  // registered outputs, one cycle after the policy
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OSC_KEEP <= 1'b1;
      CHECKS_ON <= 1'b0;
      OUTPUTS_EN <= 4'h0;
      SWITCH_EN <= 8'h00;
      BURNOUT_EN <= 8'h00;
      OUTPUT_FOUR_EN <= 1'b0;
      OUTPUT_FOUR_LEVEL <= 1'b0;
    end else begin
      OSC_KEEP <= pol.osc_keep;
      CHECKS_ON <= pol.checks_on;
      OUTPUTS_EN <= pol.outs_en;
      SWITCH_EN <= pol.switch_en;
      BURNOUT_EN <= pol.burnout_en;
      OUTPUT_FOUR_EN <= pol.out4_en;
      OUTPUT_FOUR_LEVEL <= pol.out4_lvl;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic standby;
  assign standby = context_reg[SBKC_CTX_STANDBY_BIT];

  sequence s_routed_standby;
    retention_reg[SBKC_ROUTE_BIT] && standby;
  endsequence

  chk_route_low_standby: assert property (@(posedge CLK) disable iff (RST)
    s_routed_standby |=> (OUTPUT_FOUR_EN && !OUTPUT_FOUR_LEVEL))
    else $error("output four not low in routed standby");
  chk_route_high_convert: assert property (@(posedge CLK) disable iff (RST)
    (retention_reg[SBKC_ROUTE_BIT] && !standby) |=> (OUTPUT_FOUR_EN && OUTPUT_FOUR_LEVEL))
    else $error("output four not high while converting");
  chk_unrouted_follow: assert property (@(posedge CLK) disable iff (RST)
    (!retention_reg[SBKC_ROUTE_BIT] && !standby) |=>
    (OUTPUT_FOUR_LEVEL == $past(context_reg[SBKC_CTX_OUT4_LVL_BIT])))
    else $error("output four level does not follow setting");
  chk_checks_off_sby: assert property (@(posedge CLK) disable iff (RST)
    (standby && !retention_reg[SBKC_CHECKS_BIT]) |=> !CHECKS_ON)
    else $error("checks running in standby without keep");
  chk_osc_stop_sby: assert property (@(posedge CLK) disable iff (RST)
    (standby && !context_reg[SBKC_CTX_INTOSC_BIT]) |=> !OSC_KEEP)
    else $error("oscillator kept without need");
  chk_osc_keep_all: assert property (@(posedge CLK) disable iff (RST)
    (standby && retention_reg[SBKC_CHECKS_BIT] && context_reg[SBKC_CTX_OVUV_BIT] &&
     context_reg[SBKC_CTX_INTOSC_BIT]) |=> OSC_KEEP)
    else $error("oscillator stopped while needed");
  chk_outputs_off_sby: assert property (@(posedge CLK) disable iff (RST)
    (standby && !retention_reg[SBKC_OUTPUTS_BIT]) |=> (OUTPUTS_EN == 4'h0))
    else $error("outputs active in standby without keep");
  chk_switch_off_sby: assert property (@(posedge CLK) disable iff (RST)
    (standby && !retention_reg[SBKC_SWITCH_BIT]) |=> (SWITCH_EN == 8'h00))
    else $error("switch active in standby without keep");
  chk_burnout_off_sby: assert property (@(posedge CLK) disable iff (RST)
    (standby && !retention_reg[SBKC_BURNOUT_BIT]) |=> (BURNOUT_EN == 8'h00))
    else $error("burnout on in standby without keep");
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
    retention_reg[12:9] == 4'h0)
    else $error("reserved bits not zero");
  chk_reset_clear: assert property (@(posedge CLK)
    $fell(RST) |-> (retention_reg[8:4] == 5'h00))
    else $error("keep bits not cleared by reset");

endmodule

// file: hw/sbkc_pkg.sv
// package: register map, field positions and reset values for the standby keep-alive control
package sbkc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SBKC_RETENTION_IDX = 8'h39;
  localparam logic [11:0] SBKC_RETENTION_ADDR = {2'b00, SBKC_RETENTION_IDX, 2'b00};
  localparam logic [11:0] SBKC_CONTEXT_ADDR = 12'h100;
  localparam logic [11:0] SBKC_SETUP_ADDR = 12'h104;
  localparam logic [11:0] SBKC_STATUS_ADDR = 12'h108;

  // ----------------------------------------
  // retention register fields
  // ----------------------------------------
  localparam int SBKC_ROUTE_BIT = 8;
  localparam int SBKC_CHECKS_BIT = 7;
  localparam int SBKC_OUTPUTS_BIT = 6;
  localparam int SBKC_SWITCH_BIT = 5;
  localparam int SBKC_BURNOUT_BIT = 4;
  localparam logic [15:0] SBKC_RETENTION_WMASK = 16'h81F0;
  localparam logic [15:0] SBKC_RETENTION_RESET = 16'h0000;

  // ----------------------------------------
  // context register fields (inputs the policy depends on)
  // ----------------------------------------
  localparam int SBKC_CTX_STANDBY_BIT = 0;
  localparam int SBKC_CTX_INTOSC_BIT = 1;
  localparam int SBKC_CTX_OVUV_BIT = 2;
  localparam int SBKC_CTX_CHECKS_BIT = 3;
  localparam int SBKC_CTX_OUT4_EN_BIT = 4;
  localparam int SBKC_CTX_OUT4_LVL_BIT = 5;
  localparam int SBKC_CTX_OUTS_LSB = 8;
  localparam logic [15:0] SBKC_CONTEXT_RESET = 16'h0000;

  // setup register: switch settings in [7:0], burnout settings in [15:8]
  localparam int SBKC_SETUP_BURN_LSB = 8;
  localparam logic [15:0] SBKC_SETUP_RESET = 16'h0000;

  localparam logic [31:0] SBKC_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {SBKC_IDLE, SBKC_ACCESS} sbkc_apb_state_t;

endpackage

// file: hw/sbkc_if.sv
// interface: policy inputs carried from the register file to the gating logic
interface sbkc_policy_if;
  import sbkc_pkg::*;
  logic [15:0] retention;
  logic [15:0] context_bits;
  logic [15:0] setup;
  logic osc_keep;
  logic checks_on;
  logic [3:0] outs_en;
  logic [7:0] switch_en;
  logic [7:0] burnout_en;
  logic out4_en;
  logic out4_lvl;
  modport regs (output retention, context_bits, setup,
                input osc_keep, checks_on, outs_en, switch_en, burnout_en, out4_en, out4_lvl);
  modport gate (input retention, context_bits, setup,
                output osc_keep, checks_on, outs_en, switch_en, burnout_en, out4_en, out4_lvl);
endinterface

// file: hw/sbkc_gate.sv
// module: combinational standby gating of auxiliary functions
module sbkc_gate
  import sbkc_pkg::*;
(
  sbkc_policy_if.gate pol
);
  logic standby;
  logic route;
  assign standby = pol.context_bits[SBKC_CTX_STANDBY_BIT];
  assign route = pol.retention[SBKC_ROUTE_BIT];

  always_comb begin
    // checks run while converting, or in standby when kept
    pol.checks_on = pol.context_bits[SBKC_CTX_CHECKS_BIT] &
                    (~standby | pol.retention[SBKC_CHECKS_BIT]);
    // oscillator held in standby only when all three hold, else stopped to save power
    pol.osc_keep = ~standby | (pol.retention[SBKC_CHECKS_BIT] & pol.context_bits[SBKC_CTX_OVUV_BIT] &
                   pol.context_bits[SBKC_CTX_INTOSC_BIT]);
    pol.outs_en = pol.context_bits[SBKC_CTX_OUTS_LSB +: 4] &
                  {4{~standby | pol.retention[SBKC_OUTPUTS_BIT]}};
    pol.switch_en = pol.setup[7:0] & {8{~standby | pol.retention[SBKC_SWITCH_BIT]}};
    pol.burnout_en = pol.setup[SBKC_SETUP_BURN_LSB +: 8] &
                     {8{~standby | pol.retention[SBKC_BURNOUT_BIT]}};
    if (route) begin
      // active-low indicator, settings for output four ignored
      pol.out4_en = 1'b1;
      pol.out4_lvl = ~standby;
    end else begin
      pol.out4_en = pol.context_bits[SBKC_CTX_OUT4_EN_BIT] & (~standby | pol.retention[SBKC_OUTPUTS_BIT]);
      pol.out4_lvl = pol.context_bits[SBKC_CTX_OUT4_LVL_BIT];
    end
  end
endmodule

// file: verification/tb_top.sv
// testbench: random and corner checks of the standby keep-alive control
module tb_top
  import sbkc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, osc_keep, checks_on, out4_en, out4_lvl, er;
  logic [3:0] outs_en;
  logic [7:0] switch_en, burnout_en;
  logic [31:0] seed = 32'hC7B025B7;
  logic [31:0] r32, s, m;
  logic [15:0] ret, ctx, stp;
  int n_errors = 0;
  int n_checks = 0;
  int i;
  // everything on, routed standby, standby with no internal clock, gated outputs
  logic [15:0] c_ret [4] = '{16'hFFFF, 16'h0100, 16'h0080, 16'h0000};
  logic [15:0] c_ctx [4] = '{16'hFFFF, 16'h0001, 16'h0005, 16'h0F31};
  logic [15:0] c_stp [4] = '{16'hFFFF, 16'hA5C3, 16'h00FF, 16'hFFFF};

  initial begin
    forever #12.5 clk = ~clk;
  end

  sbkc_top i_sbkc_top (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OSC_KEEP(osc_keep), .CHECKS_ON(checks_on), .OUTPUTS_EN(outs_en), .SWITCH_EN(switch_en),
    .BURNOUT_EN(burnout_en), .OUTPUT_FOUR_EN(out4_en), .OUTPUT_FOUR_LEVEL(out4_lvl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected outputs packed in the status register layout
  function automatic logic [31:0] expect_status(logic [15:0] rt, logic [15:0] cx, logic [15:0] st);
    logic awake;
    logic [31:0] e;
    awake = ~cx[0];
    e = 32'h0000_0000;
    e[0] = awake | (rt[7] & cx[2] & cx[1]);
    e[2] = cx[3] & (awake | rt[7]);
    e[3] = rt[8] | (cx[4] & (awake | rt[6]));
    e[4] = rt[8] ? awake : cx[5];
    e[9:6] = (awake | rt[6]) ? cx[11:8] : 4'h0;
    e[17:10] = (awake | rt[5]) ? st[7:0] : 8'h00;
    e[25:18] = (awake | rt[4]) ? st[15:8] : 8'h00;
    return e;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      give_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // out four level only matters while it is driven
  task automatic check_ports(input logic [31:0] e);
    check({31'h0, osc_keep}, {31'h0, e[0]}, "osc keep");
    check({31'h0, checks_on}, {31'h0, e[2]}, "checks on");
    check({28'h0, outs_en}, {28'h0, e[9:6]}, "outputs");
    check({24'h0, switch_en}, {24'h0, e[17:10]}, "switch");
    check({24'h0, burnout_en}, {24'h0, e[25:18]}, "burnout");
    check({30'h0, out4_en, out4_lvl & e[3]}, {30'h0, e[3], e[4] & e[3]}, "out four");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_ports(32'h0000_0001);
    apb(1'b0, SBKC_RETENTION_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000, "retention reset");
    $display("test reset done");
    for (i = 0; i < 40; i++) begin
      r32 = rnd();
      ret = (i < 4) ? c_ret[i] : r32[15:0];
      r32 = rnd();
      ctx = (i < 4) ? c_ctx[i] : r32[15:0];
      r32 = rnd();
      stp = (i < 4) ? c_stp[i] : r32[15:0];
      apb(1'b1, SBKC_RETENTION_ADDR, {16'hFFFF, ret});
      apb(1'b1, SBKC_CONTEXT_ADDR, {16'h0000, ctx});
      apb(1'b1, SBKC_SETUP_ADDR, {16'h0000, stp});
      repeat (3) @(posedge clk);
      s = expect_status(ret, ctx, stp);
      check_ports(s);
      apb(1'b0, SBKC_RETENTION_ADDR, 32'h0000_0000);
      check(rd, {16'h0000, ret & 16'h81F0}, "retention readback");
      m = s[3] ? 32'hFFFF_FFFF : 32'hFFFF_FFEF;
      apb(1'b0, SBKC_STATUS_ADDR, 32'h0000_0000);
      check(rd & m, s & m, "status");
      check({31'h0, er}, 32'h0000_0000, "mapped read error");
    end
    $display("test random policy done");
    // unmapped write must not disturb the retention bits
    apb(1'b1, 12'h0E0, 32'h0000_0100);
    check({31'h0, er}, 32'h0000_0001, "unmapped write error");
    apb(1'b0, 12'h200, 32'h0000_0000);
    check({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, SBKC_RETENTION_ADDR, 32'h0000_0000);
    check(rd, {16'h0000, ret & 16'h81F0}, "retention kept");
    $display("test unmapped done");
    give_verdict();
  end
endmodule
